// >>> rtl/dac_regs_cfg.svh
`ifndef DAC_REGS_CFG_SVH
`define DAC_REGS_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DAC_OFS_LOAD_RESET_CTRL 8'h05
`define DAC_OFS_BROADCAST_CODE 8'h06
`define DAC_OFS_FAULT_SUMMARY 8'h07

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DAC_PAIR_LOAD_MSB 15
`define DAC_PAIR_LOAD_LSB 8
`define DAC_SOFT_RESET_MSB 3
`define DAC_SOFT_RESET_LSB 0
`define DAC_BCAST_CODE_MSB 15
`define DAC_BCAST_CODE_LSB 4
`define DAC_ANY_SHORT_BIT 0

// ----------------------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------------------
`define DAC_LOAD_RESET_CTRL_RST 16'h0000
`define DAC_BROADCAST_CODE_RST 16'h0000
`define DAC_FAULT_SUMMARY_RST 16'h4008
`define DAC_FAULT_RSVD_VALUE 15'h2004
`define DAC_SOFT_RESET_KEY 4'ha
`define DAC_CODE_RST 12'h000
`define DAC_READ_ZERO 16'h0000

`endif

// >>> rtl/dac_regs_pkg.sv
`default_nettype none
package dac_regs_pkg;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef logic [11:0] code_t;
  typedef logic [15:0] reg_word_t;
  typedef logic [15:0] chan_mask_t;
  typedef logic [7:0] pair_mask_t;

  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_LOAD_RESET = 4'b0010,
    SEL_BCAST = 4'b0100,
    SEL_FAULT = 4'b1000
  } reg_sel_t;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b01,
    RST_APPLY = 2'b10
  } soft_rst_state_t;

endpackage : dac_regs_pkg
`default_nettype wire

// >>> rtl/dac_channel_slice.sv
`timescale 1ns/100ps
`default_nettype none
`include "dac_regs_cfg.svh"

module dac_channel_slice
  import dac_regs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_soft_clr,
  // Channel controls
  input wire logic i_sync_mode,
  input wire logic i_buf_wr,
  input wire code_t i_buf_code,
  input wire logic i_load,
  input wire logic i_bcast_en,
  input wire logic i_bcast_wr,
  input wire code_t i_bcast_code,
  // Channel codes
  output code_t o_buffer_code,
  output code_t o_active_code
);

  code_t buffer_code;
  code_t active_code;
  code_t next_buffer_code;
  code_t next_active_code;
  logic take_bcast;

  // ----------------------------------------------------------------------------
  // Update selection
  // ----------------------------------------------------------------------------
  assign take_bcast = i_bcast_wr & i_bcast_en;
  assign next_buffer_code = take_bcast ? i_bcast_code :
                            i_buf_wr ? i_buf_code : buffer_code;
  // Broadcast wins; asynchronous channels follow their buffer at once
  assign next_active_code = take_bcast ? i_bcast_code :
                            (i_load & i_sync_mode) ? buffer_code :
                            (i_buf_wr & ~i_sync_mode) ? i_buf_code : active_code;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buffer_code <= `DAC_CODE_RST;
      active_code <= `DAC_CODE_RST;
    end else if (i_soft_clr) begin
      buffer_code <= `DAC_CODE_RST;
      active_code <= `DAC_CODE_RST;
    end else begin
      buffer_code <= next_buffer_code;
      active_code <= next_active_code;
    end
  end

  assign o_buffer_code = buffer_code;
  assign o_active_code = active_code;

endmodule : dac_channel_slice

`default_nettype wire

// >>> rtl/dac_trigger_broadcast_status_regs.sv
// Contract
// - Trigger bits 15 to 8 each select a channel pair, 15/14 down to 1/0.
// - A pair trigger moves buffer to active only on synchronous channels.
// - Zero bits do nothing; set trigger bits self-clear after the transfer.
// - Key Ah in bits 3:0 restarts the device and all registers except the short-circuit synchroniser and the answer to a read in the reset cycle.
// - The reset field clears itself as the reset runs.
// - Trigger register at 5h, reset 0000h, bits 7:4 read zero.
// - Broadcast code loads buffer and active of every broadcast-enabled channel.
// - Broadcast register at 6h, reset 0000h, code readable, bits 3:0 zero.
// - Status bit 0 is the OR of all channel short flags.
// - Status at 7h, read-only, reset 4008h, bits 15:1 read 2004h.
// - Channel short flags are held one bit per channel separately.
`timescale 1ns/100ps
`default_nettype none
`include "dac_regs_cfg.svh"

module dac_trigger_broadcast_status_regs
  import dac_regs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Per-channel configuration
  input wire logic [15:0] i_sync_mode,
  input wire logic [15:0] i_bcast_en,
  // Per-channel buffer writes
  input wire logic [15:0] i_chan_buf_wr,
  input wire logic [11:0] i_chan_buf_code,
  // Short-circuit detectors, asynchronous
  input wire logic [15:0] i_short_detect,
  // Channel codes, channel n at bits 12n+11:12n
  output logic [191:0] o_buffer_codes,
  output logic [191:0] o_active_codes,
  // Status and device reset
  output logic [15:0] o_channel_short_flag,
  output logic o_any_channel_short_flag,
  output logic o_load_busy,
  output logic o_soft_reset
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  reg_sel_t reg_sel;
  soft_rst_state_t rst_state;
  soft_rst_state_t next_rst_state;
  logic wr_load_reset;
  logic wr_bcast;
  logic rd_any;
  logic key_match;
  logic soft_clr;
  pair_mask_t pair_pending;
  pair_mask_t next_pair_pending;
  pair_mask_t wr_pair_bits;
  chan_mask_t load_chan;
  code_t bcast_code;
  code_t next_bcast_code;
  code_t wr_code;
  chan_mask_t short_meta;
  chan_mask_t short_sync;
  chan_mask_t channel_short_flag;
  logic any_short;
  reg_word_t load_reset_view;
  reg_word_t bcast_view;
  reg_word_t fault_view;
  reg_word_t next_rdata;
  reg_word_t reg_rdata;
  logic reg_rvalid;
  logic hit_load_reset;
  logic hit_bcast;
  logic hit_fault;
  logic wr_any;
  logic key_write;
  logic load_busy;
  logic [3:0] wr_reset_field;
  chan_mask_t buf_wr_gated;

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  assign hit_load_reset = (i_reg_addr == `DAC_OFS_LOAD_RESET_CTRL);
  assign hit_bcast = (i_reg_addr == `DAC_OFS_BROADCAST_CODE);
  assign hit_fault = (i_reg_addr == `DAC_OFS_FAULT_SUMMARY);

  always_comb begin
    if (hit_load_reset) begin
      reg_sel = SEL_LOAD_RESET;
    end else if (hit_bcast) begin
      reg_sel = SEL_BCAST;
    end else if (hit_fault) begin
      reg_sel = SEL_FAULT;
    end else begin
      reg_sel = SEL_NONE;
    end
  end

  // ----------------------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------------------
  // Writes are dropped in the cycle the soft reset is applied
  assign wr_any = i_reg_wr & ~soft_clr;
  assign wr_load_reset = wr_any & (reg_sel == SEL_LOAD_RESET);
  assign wr_bcast = wr_any & (reg_sel == SEL_BCAST);
  assign rd_any = i_reg_rd & ~i_reg_wr;
  assign buf_wr_gated = i_chan_buf_wr & ~{16{soft_clr}};

  // ----------------------------------------------------------------------------
  // Write data fields
  // ----------------------------------------------------------------------------
  assign wr_pair_bits = i_reg_wdata[`DAC_PAIR_LOAD_MSB:`DAC_PAIR_LOAD_LSB];
  assign wr_reset_field = i_reg_wdata[`DAC_SOFT_RESET_MSB:`DAC_SOFT_RESET_LSB];
  assign wr_code = i_reg_wdata[`DAC_BCAST_CODE_MSB:`DAC_BCAST_CODE_LSB];

  // ----------------------------------------------------------------------------
  // Software reset sequencer
  // ----------------------------------------------------------------------------
  assign key_match = (wr_reset_field == `DAC_SOFT_RESET_KEY);
  assign key_write = wr_load_reset & key_match;

  always_comb begin
    next_rst_state = rst_state;
    case (rst_state)
      RST_IDLE: begin
        if (key_write) begin
          next_rst_state = RST_APPLY;
        end
      end
      RST_APPLY: begin
        next_rst_state = RST_IDLE;
      end
      default: begin
        next_rst_state = RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_state <= RST_IDLE;
    end else begin
      rst_state <= next_rst_state;
    end
  end

  // One-cycle clear of the trigger, broadcast, channel and short flag registers; the synchroniser keeps its state
  assign soft_clr = (rst_state == RST_APPLY);

  // ----------------------------------------------------------------------------
  // Pair load triggers
  // ----------------------------------------------------------------------------
  // Pending bits live one cycle; a new write in that cycle wins over the clear
  assign next_pair_pending = wr_load_reset ? wr_pair_bits : 8'h00;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pair_pending <= 8'h00;
    end else if (soft_clr) begin
      pair_pending <= 8'h00;
    end else begin
      pair_pending <= next_pair_pending;
    end
  end

  // Each pending pair bit drives both of its channels
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++) begin : g_pair
      assign load_chan[2*gp] = pair_pending[gp];
      assign load_chan[2*gp+1] = pair_pending[gp];
    end
  endgenerate

  assign load_busy = |pair_pending;

  // ----------------------------------------------------------------------------
  // Broadcast code
  // ----------------------------------------------------------------------------
  assign next_bcast_code = wr_bcast ? wr_code : bcast_code;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bcast_code <= `DAC_CODE_RST;
    end else if (soft_clr) begin
      bcast_code <= `DAC_CODE_RST;
    end else begin
      bcast_code <= next_bcast_code;
    end
  end

  // ----------------------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < 16; gc++) begin : g_chan
      dac_channel_slice u_slice (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_soft_clr(soft_clr),
        .i_sync_mode(i_sync_mode[gc]),
        .i_buf_wr(buf_wr_gated[gc]),
        .i_buf_code(i_chan_buf_code),
        .i_load(load_chan[gc]),
        .i_bcast_en(i_bcast_en[gc]),
        .i_bcast_wr(wr_bcast),
        .i_bcast_code(wr_code),
        .o_buffer_code(o_buffer_codes[12*gc+11:12*gc]),
        .o_active_code(o_active_codes[12*gc+11:12*gc])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Short-circuit synchroniser
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      short_meta <= 16'h0000;
      short_sync <= 16'h0000;
    end else begin
      short_meta <= i_short_detect;
      short_sync <= short_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // Channel status
  // ----------------------------------------------------------------------------
  // Separate per-channel status, one bit each
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      channel_short_flag <= 16'h0000;
    end else if (soft_clr) begin
      channel_short_flag <= 16'h0000;
    end else begin
      channel_short_flag <= short_sync;
    end
  end

  assign any_short = |channel_short_flag;
  assign o_channel_short_flag = channel_short_flag;
  assign o_any_channel_short_flag = any_short;

  // ----------------------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------------------
  assign load_reset_view = `DAC_LOAD_RESET_CTRL_RST;
  assign bcast_view = {bcast_code, 4'h0};
  assign fault_view = {`DAC_FAULT_RSVD_VALUE, any_short};

  always_comb begin
    if (reg_sel == SEL_LOAD_RESET) begin
      next_rdata = load_reset_view;
    end else if (reg_sel == SEL_BCAST) begin
      next_rdata = bcast_view;
    end else if (reg_sel == SEL_FAULT) begin
      next_rdata = fault_view;
    end else begin
      next_rdata = `DAC_READ_ZERO;
    end
  end

  // ----------------------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------------------
  // Answer strobe follows each accepted read by one cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_any;
    end
  end

  // A read in the soft reset cycle still gets its answer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reg_rdata <= `DAC_READ_ZERO;
    end else if (rd_any) begin
      reg_rdata <= next_rdata;
    end else if (soft_clr) begin
      reg_rdata <= `DAC_READ_ZERO;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign o_reg_rdata = reg_rdata;
  assign o_reg_rvalid = reg_rvalid;
  assign o_load_busy = load_busy;
  assign o_soft_reset = soft_clr;

endmodule : dac_trigger_broadcast_status_regs

`default_nettype wire

// >>> tb/dac_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dac_regs_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // Status
  input wire logic [15:0] o_channel_short_flag,
  input wire logic o_any_channel_short_flag,
  input wire logic o_load_busy,
  input wire logic o_soft_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic ctl_wr = i_reg_wr && i_reg_addr == 8'h05 && !o_soft_reset;
  wire logic key = i_reg_wdata[3:0] == 4'ha;
  wire logic rd_go = i_reg_rd && !i_reg_wr;
  property p_trig; ctl_wr && |i_reg_wdata[15:8] && !key |=> o_load_busy; endproperty
  a_trig: assert property (p_trig)
    else $error("pair load not pending");
  property p_selfclr; o_load_busy && !ctl_wr |=> !o_load_busy; endproperty
  a_selfclr: assert property (p_selfclr)
    else $error("pair load not cleared");
  property p_zero; ctl_wr && i_reg_wdata[15:8] == 8'h00 |=> !o_load_busy; endproperty
  a_zero: assert property (p_zero)
    else $error("zero trigger acted");
  property p_key; ctl_wr && key |=> o_soft_reset ##1 !o_soft_reset; endproperty
  a_key: assert property (p_key)
    else $error("soft reset pulse wrong");
  property p_nokey; !(ctl_wr && key) |=> !o_soft_reset; endproperty
  a_nokey: assert property (p_nokey)
    else $error("soft reset without key");
  property p_clr; o_soft_reset |=> o_channel_short_flag == 16'h0000 && !o_load_busy; endproperty
  a_clr: assert property (p_clr)
    else $error("state kept over soft reset");
  property p_stat;
    rd_go && i_reg_addr == 8'h07 |=>
      o_reg_rvalid && o_reg_rdata == {15'h2004, $past(o_any_channel_short_flag)};
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read wrong");
  property p_ctl_rd; rd_go && i_reg_addr == 8'h05 |=> o_reg_rdata == 16'h0000; endproperty
  a_ctl_rd: assert property (p_ctl_rd)
    else $error("control read not zero");
  property p_bc_rd; rd_go && i_reg_addr == 8'h06 |=> o_reg_rdata[3:0] == 4'h0; endproperty
  a_bc_rd: assert property (p_bc_rd)
    else $error("broadcast low bits set");
  property p_any; o_any_channel_short_flag == |o_channel_short_flag; endproperty
  a_any: assert property (p_any)
    else $error("summary flag wrong");
endmodule : dac_regs_chk
bind dac_trigger_broadcast_status_regs dac_regs_chk chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_channel_short_flag(o_channel_short_flag),
  .o_any_channel_short_flag(o_any_channel_short_flag), .o_load_busy(o_load_busy),
  .o_soft_reset(o_soft_reset));
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input wire logic i_clk,
  // Register port drive
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  // One strobe cycle; released lines show the inverse
  task automatic put(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : put
endmodule : host_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dac_regs_pkg::*;
  logic clk, arst_n;
  logic [15:0] sync, bcen, bwr, sdet, r;
  code_t bcode, cv;
  wire logic wr, rd, rv, any, busy, srst;
  wire logic [7:0] addr;
  wire logic [15:0] wd, rdat, flags;
  wire logic [191:0] bufs, acts;
  code_t bm[16], am[16];
  reg_word_t q[$];
  int fails, check_count, seed;
  host_model host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd));
  dac_trigger_broadcast_status_regs dut (.i_clk(clk), .i_arst_n(arst_n), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .o_reg_rvalid(rv), .i_sync_mode(sync), .i_bcast_en(bcen), .i_chan_buf_wr(bwr),
    .i_chan_buf_code(bcode), .i_short_detect(sdet), .o_buffer_codes(bufs),
    .o_active_codes(acts), .o_channel_short_flag(flags), .o_any_channel_short_flag(any),
    .o_load_busy(busy), .o_soft_reset(srst));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [191:0] e, input logic [191:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cmp;
    logic [191:0] eb, ea;
    for (int n = 0; n < 16; n++) begin
      eb[12*n +: 12] = bm[n];
      ea[12*n +: 12] = am[n];
    end
    chk("buffers", eb, bufs);
    chk("actives", ea, acts);
  endtask : cmp
  task automatic rdq(input logic [7:0] a, input reg_word_t e);
    q.push_back(e);
    host.put(1'b0, a, 16'h0000);
  endtask : rdq
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // ----------------
  // Read results
  // ----------------
  always @(negedge clk) if (rv === 1'b1) begin
    if (q.size() == 0) begin
      fails++;
      $display("wrong value rvalid expected 0 seen 1");
    end
    else chk("rdata", q.pop_front(), rdat);
  end
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    seed = 42182;
    arst_n = 1'b0;
    {sync, bcen, bwr, sdet, bcode} = '0;
    for (int n = 0; n < 16; n++) begin
      bm[n] = 12'h000;
      am[n] = 12'h000;
    end
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rdq(8'h05, 16'h0000);
    rdq(8'h06, 16'h0000);
    rdq(8'h07, 16'h4008);
    rdq(8'h20, 16'h0000);
    r = 16'($random(seed));
    sync <= r;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      cv = code_t'($random(seed));
      bwr <= 16'h0001 << n;
      bcode <= cv;
      bm[n] = cv;
      if (!r[n]) am[n] = cv;
    end
    @(posedge clk);
    bwr <= 16'h0000;
    repeat (2) @(negedge clk);
    cmp();
    host.put(1'b1, 8'h05, 16'h0000);
    repeat (3) @(negedge clk);
    cmp();
    r = 16'($random(seed));
    host.put(1'b1, 8'h05, {r[7:0], 8'h00});
    for (int n = 0; n < 16; n++) if (r[n/2] && sync[n]) am[n] = bm[n];
    repeat (3) @(negedge clk);
    cmp();
    chk("busy", 1'b0, busy);
    @(posedge clk);
    r = 16'($random(seed));
    bcen <= r;
    cv = code_t'($random(seed));
    host.put(1'b1, 8'h06, {cv, 4'h5});
    for (int n = 0; n < 16; n++) if (r[n]) {bm[n], am[n]} = {cv, cv};
    repeat (2) @(negedge clk);
    cmp();
    rdq(8'h06, {cv, 4'h0});
    @(posedge clk);
    sdet <= 16'h8000;
    repeat (5) @(negedge clk);
    chk("flags", 16'h8000, flags);
    chk("any", 1'b1, any);
    rdq(8'h07, 16'h4009);
    @(posedge clk);
    sdet <= 16'h0000;
    repeat (5) @(negedge clk);
    rdq(8'h07, 16'h4008);
    host.put(1'b1, 8'h05, 16'h0005);
    repeat (3) @(negedge clk);
    cmp();
    host.put(1'b1, 8'h05, 16'h000a);
    for (int n = 0; n < 16; n++) {bm[n], am[n]} = 24'h00_0000;
    repeat (3) @(negedge clk);
    cmp();
    chk("soft reset", 1'b0, srst);
    rdq(8'h06, 16'h0000);
    for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge clk);
    if (q.size() != 0) begin
      fails++;
      $display("wrong value pending reads expected 0 seen %0d", q.size());
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
